// file: rcst_pkg.sv
// package: constants, types and state layout of the reset-cause and start-up timer block
package rcst_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int unsigned CLK_MHZ = 20;
  localparam int unsigned PWRT_US = 72000; // power-up timer, 72 ms
  localparam int unsigned PWRT_CYC = PWRT_US * CLK_MHZ;
  localparam int unsigned OST_CYC = 1024; // oscillator start-up, in oscillator periods
  localparam int unsigned CLEAR_FILT_NS = 2000; // least accepted master-clear pulse
  localparam int unsigned CLEAR_FILT_CYC = (CLEAR_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W = 21;
  localparam int unsigned FILT_W = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam int unsigned ADDR_W = 14;
  localparam logic [13:0] OFS_OPTION = 14'h0081;
  localparam logic [13:0] OFS_CONFIG = 14'h2007;
  localparam logic [13:0] OFS_POWER_STATUS = 14'h008e;
  localparam logic [13:0] OFS_EVT_STATUS = 14'h0090;
  localparam logic [13:0] OFS_EVT_MASK = 14'h0091;
  localparam logic [13:0] OFS_SCRATCH = 14'h0092;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned PS_POWER_ON_BIT = 1;
  localparam int unsigned PS_SLEEP_BIT = 3;
  localparam int unsigned PS_EXPIRY_BIT = 4;
  localparam int unsigned CFG_PWRT_B_BIT = 3; // power_up_timer_enable, 0 = timer on
  localparam int unsigned CFG_OSC_LSB = 0; // oscillator_select_high/low
  localparam int unsigned EVT_POWER_ON = 0;
  localparam int unsigned EVT_CLEAR_RUN = 1;
  localparam int unsigned EVT_CLEAR_SLEEP = 2;
  localparam int unsigned EVT_WATCHDOG_RESET = 3;
  localparam int unsigned EVT_WATCHDOG_WAKE = 4;
  localparam int unsigned EVT_N = 5;

  // oscillator select encodings
  localparam logic [1:0] OSC_LOW_POWER = 2'h0;
  localparam logic [1:0] OSC_STANDARD = 2'h1;
  localparam logic [1:0] OSC_HIGH_SPEED = 2'h2;
  localparam logic [1:0] OSC_RES_CAP = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_OPTION = 8'hff;
  localparam logic [7:0] RST_CFG = 8'hff;
  localparam logic [4:0] RST_EVT_STATUS = 5'h01;
  localparam logic [4:0] RST_EVT_MASK = 5'h00;
  localparam logic [7:0] RST_SCRATCH = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    ST_STRAP, ST_HOLD, ST_PWRT, ST_OST, ST_RUN, ST_SLEEP
  } rcst_state_e_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr_en;
    logic rd_en;
  } rcst_bus_req_t;

  typedef struct packed {
    logic sleep_cmd; // sleep instruction executed
    logic clear_watchdog_cmd; // watchdog clear instruction executed
    logic watchdog_timeout; // one-cycle pulse on watchdog expiry
  } rcst_core_evt_t;

  typedef struct packed {
    rcst_state_e_t st;
    logic [CNT_W-1:0] cnt;
    logic warm; // running timeout is a wake-up, no core reset
    logic clear_filt;
    logic [FILT_W-1:0] filt_cnt;
    logic [7:0] cfg;
    logic [7:0] option;
    logic power_on_flag;
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
    logic [EVT_N-1:0] evt_sts;
    logic [EVT_N-1:0] evt_mask;
    logic [7:0] scratch;
    logic [7:0] rd_data;
    logic irq;
    logic core_reset_b;
    logic core_run;
  } rcst_state_t;

endpackage : rcst_pkg

// file: rcst_clk_div4.sv
// oscillator divided by four for the clock output pin
`timescale 1ns/100ps
module rcst_clk_div4 (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // control and output
  input wire logic enable,
  output logic clk_out
);

  typedef struct packed {
    logic half;
    logic out;
  } rcst_div_t;

  rcst_div_t s_q;
  rcst_div_t s_d;

  ////////////////////////////////////////////////////////////////////////////
  // toggle every second cycle, so one output period spans four clocks
  always_comb begin
    s_d = s_q;
    s_d.half = ~s_q.half;
    if (!enable) begin
      s_d.out = 1'b0; // pin belongs to the crystal in the other modes
    end else if (s_q.half) begin
      s_d.out = ~s_q.out;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign clk_out = s_q.out;

endmodule : rcst_clk_div4

// file: rcst_reset_ctrl.sv
// reset cause detection, start-up timeout, status flags and register port
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module rcst_reset_ctrl #(
  // defaults give the real timings; a test bench may shorten them
  parameter int unsigned PWRT_CYCLES = rcst_pkg::PWRT_CYC,
  parameter int unsigned CLEAR_FILT_CYCLES = rcst_pkg::CLEAR_FILT_CYC
) (
  // clock, power-on reset and clock enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // pins and straps
  input wire logic master_clear_pin_b,
  input wire logic [7:0] config_word,
  // core events
  input wire rcst_pkg::rcst_core_evt_t core_evt,
  // register port
  input wire rcst_pkg::rcst_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // results
  output logic core_reset_b,
  output logic core_run,
  output logic [7:0] timer_watchdog_option,
  output logic irq,
  output logic divided_clock_output
);
  import rcst_pkg::*;

  localparam logic [CNT_W-1:0] PWRT_LAST = CNT_W'(PWRT_CYCLES - 1);
  localparam logic [CNT_W-1:0] OST_LAST = CNT_W'(OST_CYC - 1);
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(CLEAR_FILT_CYCLES - 1);
  // counters load their last value and count down to zero, so a phase lasts
  // exactly its count of edges; the compare stays a single zero test

  // power-on image of the whole state
  localparam rcst_state_t S_RST = '{
    st: ST_STRAP,
    cnt: '0,
    warm: 1'b0,
    clear_filt: 1'b1,
    filt_cnt: '0,
    cfg: RST_CFG,
    option: RST_OPTION,
    power_on_flag: 1'b0,
    watchdog_expiry_flag: 1'b1,
    sleep_entered_flag: 1'b1,
    evt_sts: RST_EVT_STATUS,
    evt_mask: RST_EVT_MASK,
    scratch: RST_SCRATCH,
    rd_data: 8'h00,
    irq: 1'b0,
    core_reset_b: 1'b0,
    core_run: 1'b0
  };

  // working signals of the next-state logic
  rcst_state_t s_q;
  rcst_state_t s_d;
  logic crystal;
  logic pwrt_on;
  logic [EVT_N-1:0] evt_set;
  logic [EVT_N-1:0] evt_clr;
  logic cold_reset;

  // option bits from the captured configuration word
  assign crystal = (s_q.cfg[CFG_OSC_LSB +: 2] != OSC_RES_CAP);
  assign pwrt_on = ~s_q.cfg[CFG_PWRT_B_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic
  always_comb begin
    s_d = s_q;
    evt_set = '0;
    evt_clr = '0;
    cold_reset = 1'b0;

    // filter: input must differ from the accepted level for the full width;
    // a bounce during the count starts it again, so only a clean pulse counts,
    // and the release is filtered the same way so a bouncing release cannot
    // cut the hold short
    if (master_clear_pin_b == s_q.clear_filt) begin
      s_d.filt_cnt = '0;
    end else if (s_q.filt_cnt == FILT_LAST) begin
      s_d.clear_filt = master_clear_pin_b;
      s_d.filt_cnt = '0;
    end else begin
      s_d.filt_cnt = s_q.filt_cnt + FILT_W'(1);
    end

    // sequencer
    unique case (s_q.st)
      ST_STRAP: begin
        // the straps are read once; a later change has no effect until the
        // next power-on, as on a part whose fuses are blown
        s_d.cfg = config_word; // straps caught on the first edge after release
        if (!s_q.clear_filt) begin // pin already held low at power-up
          s_d.st = ST_HOLD;
        end else if (!config_word[CFG_PWRT_B_BIT]) begin
          s_d.st = ST_PWRT;
          s_d.cnt = PWRT_LAST;
        end else if (config_word[CFG_OSC_LSB +: 2] != OSC_RES_CAP) begin
          s_d.st = ST_OST;
          s_d.cnt = OST_LAST;
        end else begin
          s_d.st = ST_RUN;
        end
      end
      ST_HOLD: begin
        // wait for the pin to be released, then run the cold timeout;
        // a watchdog reset passes through here for one cycle with the pin high
        if (s_q.clear_filt) begin
          s_d.warm = 1'b0;
          if (pwrt_on) begin
            s_d.st = ST_PWRT;
            s_d.cnt = PWRT_LAST;
          end else if (crystal) begin
            s_d.st = ST_OST;
            s_d.cnt = OST_LAST;
          end else begin
            s_d.st = ST_RUN;
          end
        end
      end
      ST_PWRT: begin
        // power-up timer first, then the crystal start-up count
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else if (crystal) begin // crystal adds the start-up count
          s_d.st = ST_OST;
          s_d.cnt = OST_LAST;
        end else begin
          s_d.st = ST_RUN;
        end
      end
      ST_OST: begin
        // crystal start-up, also used alone after a wake-up
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - CNT_W'(1);
        end else begin
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        if (core_evt.watchdog_timeout) begin
          // watchdog reset while running: reload, restart the cold timeout
          evt_set[EVT_WATCHDOG_RESET] = 1'b1;
          s_d.watchdog_expiry_flag = 1'b0;
          cold_reset = 1'b1;
          s_d.st = ST_HOLD;
        end else if (core_evt.sleep_cmd) begin
          // core halted but not reset, so its state survives the nap
          s_d.watchdog_expiry_flag = 1'b1;
          s_d.sleep_entered_flag = 1'b0;
          s_d.st = ST_SLEEP;
        end else if (core_evt.clear_watchdog_cmd) begin
          // a watchdog clear puts both flags back to their running value
          s_d.watchdog_expiry_flag = 1'b1;
          s_d.sleep_entered_flag = 1'b1;
        end
      end
      ST_SLEEP: begin
        if (core_evt.watchdog_timeout) begin
          // wake-up resumes execution, registers keep their values
          evt_set[EVT_WATCHDOG_WAKE] = 1'b1;
          s_d.watchdog_expiry_flag = 1'b0;
          s_d.sleep_entered_flag = 1'b0;
          s_d.warm = 1'b1;
          if (crystal) begin // no start-up count without a crystal
            s_d.st = ST_OST;
            s_d.cnt = OST_LAST;
          end else begin
            s_d.st = ST_RUN;
          end
        end
      end
      default: begin
        // illegal code: fall back to a held reset rather than run blind
        s_d.st = ST_HOLD;
      end
    endcase

    // master clear overrides every state except capture and hold; a watchdog
    // event in the same cycle is dropped, since the pin reset is the one that
    // software must see as the cause
    if (!s_q.clear_filt && s_q.st != ST_STRAP && s_q.st != ST_HOLD) begin
      cold_reset = 1'b1;
      evt_set = '0;
      s_d.st = ST_HOLD;
      if (s_q.st == ST_SLEEP) begin
        evt_set[EVT_CLEAR_SLEEP] = 1'b1;
        s_d.watchdog_expiry_flag = 1'b1;
        s_d.sleep_entered_flag = 1'b0;
      end else begin
        evt_set[EVT_CLEAR_RUN] = 1'b1; // flags left unchanged
        s_d.watchdog_expiry_flag = s_q.watchdog_expiry_flag;
        s_d.sleep_entered_flag = s_q.sleep_entered_flag;
      end
    end

    // register writes; reset reload and hardware events take precedence
    if (bus_req.wr_en) begin
      unique case (bus_req.addr)
        OFS_OPTION: s_d.option = bus_req.wdata;
        OFS_POWER_STATUS: begin
          s_d.power_on_flag = bus_req.wdata[PS_POWER_ON_BIT];
        end
        OFS_EVT_STATUS: evt_clr = bus_req.wdata[EVT_N-1:0];
        OFS_EVT_MASK: s_d.evt_mask = bus_req.wdata[EVT_N-1:0];
        OFS_SCRATCH: s_d.scratch = bus_req.wdata; // no reload on a master-clear or watchdog reset
        default: begin
        end
      endcase
    end
    // a cold reset beats a write in the same cycle
    if (cold_reset) begin
      s_d.option = RST_OPTION;
      s_d.warm = 1'b0;
    end
    // the power-on flag is cleared by the power-on reset or by writing 0 to it
    s_d.power_on_flag = (bus_req.wr_en && bus_req.addr == OFS_POWER_STATUS) ?
      bus_req.wdata[PS_POWER_ON_BIT] : s_q.power_on_flag;

    // sticky causes, a new event beats a simultaneous clear
    s_d.evt_sts = (s_q.evt_sts & ~evt_clr) | evt_set;
    s_d.irq = |(s_d.evt_sts & s_d.evt_mask);

    // core reset held through the whole timeout; a wake keeps the core state
    s_d.core_run = (s_d.st == ST_RUN);
    s_d.core_reset_b = (s_d.st == ST_RUN) || (s_d.st == ST_SLEEP) ||
      (s_d.st == ST_OST && s_d.warm);

    // read data stand only in the cycle after the strobe;
    // reads have no side effects, so polling never loses a cause
    s_d.rd_data = 8'h00;
    if (bus_req.rd_en) begin
      unique case (bus_req.addr)
        OFS_OPTION: s_d.rd_data = s_q.option;
        OFS_CONFIG: s_d.rd_data = s_q.cfg;
        OFS_POWER_STATUS: begin
          s_d.rd_data[PS_POWER_ON_BIT] = s_q.power_on_flag;
          s_d.rd_data[PS_SLEEP_BIT] = s_q.sleep_entered_flag;
          s_d.rd_data[PS_EXPIRY_BIT] = s_q.watchdog_expiry_flag;
        end
        OFS_EVT_STATUS: s_d.rd_data[EVT_N-1:0] = s_q.evt_sts;
        OFS_EVT_MASK: s_d.rd_data[EVT_N-1:0] = s_q.evt_mask;
        OFS_SCRATCH: s_d.rd_data = s_q.scratch;
        default: s_d.rd_data = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register; power-on sets expiry and sleep flags, clears power-on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= S_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock output, active only with the resistor-capacitor oscillator;
  // with a crystal the pin belongs to the oscillator and stays low
  rcst_clk_div4 u_clk_div4 (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .enable(~crystal),
    .clk_out(divided_clock_output)
  );

  // outputs straight from the state register,
  // so none can glitch while the next-state logic settles
  assign rd_data = s_q.rd_data;
  assign core_reset_b = s_q.core_reset_b;
  assign core_run = s_q.core_run;
  assign timer_watchdog_option = s_q.option;
  assign irq = s_q.irq;

endmodule : rcst_reset_ctrl

// file: rcst_reset_ctrl_properties.sv
// checker: port-level properties of the reset-cause block
`timescale 1ns/100ps
module rcst_reset_ctrl_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // stimulus
  input wire logic master_clear_pin_b,
  input wire logic [7:0] config_word,
  input wire rcst_pkg::rcst_core_evt_t core_evt,
  input wire rcst_pkg::rcst_bus_req_t bus_req,
  // results
  input wire logic [7:0] rd_data,
  input wire logic core_reset_b,
  input wire logic core_run,
  input wire logic [7:0] timer_watchdog_option,
  input wire logic irq,
  input wire logic divided_clock_output
);
  import rcst_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  // register port and core hold
  property p_rd_idle; !bus_req.rd_en |=> rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_run_rst; core_run |-> core_reset_b; endproperty
  a_run_rst: assert property (p_run_rst) else $error("run while core in reset");
  // a fall of core reset needs a long low pin or a watchdog pulse
  property p_clear_filt;
    $fell(core_reset_b) |-> (!$past(master_clear_pin_b, 1) && !$past(master_clear_pin_b, 2)
      && !$past(master_clear_pin_b, 3)) || $past(core_evt.watchdog_timeout, 1)
      || $past(core_evt.watchdog_timeout, 2) || $past(core_evt.watchdog_timeout, 3);
  endproperty
  a_clear_filt: assert property (p_clear_filt) else $error("reset without cause");
  property p_opt_reload; $fell(core_reset_b) |-> ##[0:2] timer_watchdog_option == RST_OPTION;
  endproperty
  a_opt_reload: assert property (p_opt_reload) else $error("option not reloaded");
  ////////////////////////////////////////////////////////////////////////////
  // sleep and watchdog
  property p_sleep; core_run && core_evt.sleep_cmd |=> !core_run; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep did not halt");
  // wake-up resumes execution, so core registers must not be touched
  property p_wake; core_reset_b && !core_run && core_evt.watchdog_timeout |=> core_reset_b [*2];
  endproperty
  a_wake: assert property (p_wake) else $error("wake-up reset the core");
  property p_watchdog_rst;
    core_run && core_evt.watchdog_timeout |-> ##[1:3] !core_reset_b;
  endproperty
  a_watchdog_rst: assert property (p_watchdog_rst) else $error("watchdog did not reset");
  ////////////////////////////////////////////////////////////////////////////
  // divided clock; straps settle a few cycles after reset release
  property p_clk_quiet;
    $past(rst_b, 8) && config_word[1:0] != OSC_RES_CAP |-> !divided_clock_output;
  endproperty
  a_clk_quiet: assert property (p_clk_quiet) else $error("clock out with a crystal");
  property p_clk_div;
    config_word[1:0] == OSC_RES_CAP && $rose(divided_clock_output) |=> divided_clock_output
      ##1 !divided_clock_output [*2] ##1 divided_clock_output;
  endproperty
  a_clk_div: assert property (p_clk_div) else $error("clock out not divided by 4");
  // main scenarios reached
  c_wake: cover property (core_reset_b && !core_run && core_evt.watchdog_timeout);
  c_clear: cover property ($fell(core_reset_b) && !master_clear_pin_b);
  c_irq: cover property ($rose(irq));
endmodule : rcst_reset_ctrl_properties

// file: rcst_pin_model.sv
// partner: master-clear button and oscillator strap parts
`timescale 1ns/100ps
module rcst_pin_model (
  // clock
  input wire logic clk,
  // pins toward the block
  output logic master_clear_pin_b,
  output logic [7:0] config_word
);
  import rcst_pkg::*;
  // button released, all straps unprogrammed
  initial begin
    master_clear_pin_b = 1'b1;
    config_word = 8'hff;
  end
  // hold the button for n cycles, changed just after an edge
  task automatic press(input int n);
    @(posedge clk);
    master_clear_pin_b <= 1'b0;
    repeat (n) @(posedge clk);
    master_clear_pin_b <= 1'b1;
  endtask : press
  // fitted oscillator and timer option; only legal while in reset
  task automatic strap(input logic [1:0] osc, input logic pwrt_on);
    config_word <= {4'hf, ~pwrt_on, 1'b1, osc};
  endtask : strap
endmodule : rcst_pin_model

// file: rcst_reset_ctrl_tb.sv
// testbench: reset causes, start-up timeouts, flags and registers
`timescale 1ns/100ps
module rcst_reset_ctrl_tb;
  import rcst_pkg::*;
  localparam int P = 50;
  logic clk, rst_b, master_clear_pin_b, core_reset_b, core_run, irq, divided_clock_output;
  logic [7:0] config_word, rd_data, timer_watchdog_option;
  logic ce;
  rcst_core_evt_t core_evt;
  rcst_bus_req_t bus_req;
  int num_errors = 0;
  int n_tests = 0;
  // short power-up timer keeps the run brief
  rcst_reset_ctrl #(.PWRT_CYCLES(P), .CLEAR_FILT_CYCLES(3)) dut_u (.clk(clk), .rst_b(rst_b),
    .ce(ce), .master_clear_pin_b(master_clear_pin_b), .config_word(config_word),
    .core_evt(core_evt), .bus_req(bus_req), .rd_data(rd_data), .core_reset_b(core_reset_b),
    .core_run(core_run), .timer_watchdog_option(timer_watchdog_option), .irq(irq),
    .divided_clock_output(divided_clock_output));
  rcst_pin_model mdl_u (.clk(clk), .master_clear_pin_b(master_clear_pin_b),
    .config_word(config_word));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // report, compare and bus tasks
  task automatic stop_test();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask : chk
  // cycle counts get a small margin for pipeline edges
  task automatic chk_n(input string nm, input int e, input int g);
    n_tests++;
    if (g < e - 4 || g > e + 4) begin
      $display("CHECK FAILED %s expected %0d seen %0d", nm, e, g);
      num_errors++;
    end
  endtask : chk_n
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr_en: 1'b1, rd_en: 1'b0};
    @(posedge clk);
    bus_req.wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input string nm, input logic [13:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr_en: 1'b0, rd_en: 1'b1};
    @(posedge clk);
    bus_req.rd_en <= 1'b0;
    #1;
    chk(nm, e, rd_data & m);
  endtask : rd
  task automatic pulse(input rcst_core_evt_t e);
    @(posedge clk);
    core_evt <= e;
    @(posedge clk);
    core_evt <= '0;
    #1;
  endtask : pulse
  task automatic chk_irq(input logic e);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask : chk_irq
  // rising edges of the clock output in 16 cycles: four in the
  // resistor-capacitor mode, none with a crystal
  task automatic chk_clk_out(input logic [7:0] e);
    logic [7:0] n;
    logic prev;
    n = 8'h00;
    prev = divided_clock_output;
    repeat (16) begin
      @(posedge clk);
      #1;
      if (divided_clock_output && !prev) begin
        n++;
      end
      prev = divided_clock_output;
    end
    chk("clock out edges", e, n);
  endtask : chk_clk_out
  task automatic wait_run(input string nm, input int e);
    int n;
    n = 0;
    while (core_run !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
      if (n > 3000) begin
        num_errors++;
        stop_test();
      end
    end
    chk_n(nm, e, n);
  endtask : wait_run
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic power_on(input logic [1:0] osc, input logic on, input int e);
    rst_b <= 1'b0;
    mdl_u.strap(osc, on);
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    wait_run("power-on timeout", e);
    rd("status after power-on", OFS_POWER_STATUS, 8'h1a, 8'h18);
    chk_clk_out((osc == OSC_RES_CAP) ? 8'h04 : 8'h00);
  endtask : power_on
  task automatic regs();
    rd("option", OFS_OPTION, 8'hff, 8'hff);
    rd("event status", OFS_EVT_STATUS, 8'h1f, 8'h01);
    wr(OFS_CONFIG, 8'h00);
    rd("config", OFS_CONFIG, 8'hff, 8'hf5);
    rd("unmapped", 14'h0123, 8'hff, 8'h00);
    wr(OFS_SCRATCH, 8'h5a);
    wr(OFS_OPTION, 8'h3c);
    rd("option write", OFS_OPTION, 8'hff, 8'h3c);
    // a frozen block takes no write
    @(posedge clk);
    ce <= 1'b0;
    wr(OFS_OPTION, 8'h55);
    @(posedge clk);
    ce <= 1'b1;
    rd("option frozen", OFS_OPTION, 8'hff, 8'h3c);
    wr(OFS_POWER_STATUS, 8'h02);
    rd("power-on flag set", OFS_POWER_STATUS, 8'h1a, 8'h1a);
    wr(OFS_EVT_STATUS, 8'h1f);
    rd("event clear", OFS_EVT_STATUS, 8'h1f, 8'h00);
    chk_irq(1'b0);
  endtask : regs
  task automatic clear_run();
    mdl_u.press(2);
    repeat (6) @(posedge clk);
    #1;
    chk("run after glitch", 8'h01, {7'h00, core_run});
    mdl_u.press(10);
    #1;
    chk("core held", 8'h00, {7'h00, core_reset_b});
    wait_run("clear timeout", P + 1030);
    rd("status after clear", OFS_POWER_STATUS, 8'h1a, 8'h1a);
    rd("clear cause", OFS_EVT_STATUS, 8'h1f, 8'h02);
    rd("option reload", OFS_OPTION, 8'hff, 8'hff);
    chk("option output", 8'hff, timer_watchdog_option);
    rd("scratch kept", OFS_SCRATCH, 8'hff, 8'h5a);
  endtask : clear_run
  task automatic watchdog_run();
    wr(OFS_EVT_STATUS, 8'h1f);
    wr(OFS_EVT_MASK, 8'h08);
    pulse(3'b001);
    wait_run("watchdog timeout", P + 1027);
    rd("status after watchdog", OFS_POWER_STATUS, 8'h1a, 8'h0a);
    rd("watchdog cause", OFS_EVT_STATUS, 8'h1f, 8'h08);
    rd("scratch kept", OFS_SCRATCH, 8'hff, 8'h5a);
    chk_irq(1'b1);
    wr(OFS_EVT_MASK, 8'h00);
    chk_irq(1'b0);
    wr(OFS_EVT_MASK, 8'h08);
    chk_irq(1'b1);
    wr(OFS_EVT_STATUS, 8'h08);
    chk_irq(1'b0);
    pulse(3'b010);
    rd("status after clear cmd", OFS_POWER_STATUS, 8'h1a, 8'h1a);
  endtask : watchdog_run
  task automatic sleep_wake();
    wr(OFS_OPTION, 8'h3c);
    pulse(3'b100);
    chk("halt in sleep", 8'h00, {7'h00, core_run});
    rd("status in sleep", OFS_POWER_STATUS, 8'h1a, 8'h12);
    pulse(3'b001);
    wait_run("wake timeout", 1025);
    rd("status after wake", OFS_POWER_STATUS, 8'h1a, 8'h02);
    rd("option kept", OFS_OPTION, 8'hff, 8'h3c);
    chk("option output kept", 8'h3c, timer_watchdog_option);
    rd("wake cause", OFS_EVT_STATUS, 8'h1f, 8'h10);
  endtask : sleep_wake
  task automatic sleep_clear();
    pulse(3'b100);
    mdl_u.press(10);
    wait_run("sleep clear timeout", P + 1030);
    rd("status after sleep clear", OFS_POWER_STATUS, 8'h1a, 8'h12);
    rd("sleep clear cause", OFS_EVT_STATUS, 8'h04, 8'h04);
    rd("scratch kept", OFS_SCRATCH, 8'hff, 8'h5a);
    rd("option reload", OFS_OPTION, 8'hff, 8'hff);
  endtask : sleep_clear
  // every oscillator option, then the causes on a standard crystal
  initial begin
    rst_b = 1'b0;
    core_evt = '0;
    ce = 1'b1;
    bus_req = '0;
    power_on(OSC_RES_CAP, 1'b0, 2);
    power_on(OSC_RES_CAP, 1'b1, P + 2);
    power_on(OSC_HIGH_SPEED, 1'b0, 1026);
    power_on(OSC_LOW_POWER, 1'b1, P + 1027);
    power_on(OSC_STANDARD, 1'b1, P + 1027);
    regs();
    clear_run();
    watchdog_run();
    sleep_wake();
    sleep_clear();
    power_on(OSC_STANDARD, 1'b1, P + 1027);
    stop_test();
  end
endmodule : rcst_reset_ctrl_tb
bind rcst_reset_ctrl rcst_reset_ctrl_properties chk_u (.clk(clk), .rst_b(rst_b),
  .master_clear_pin_b(master_clear_pin_b), .config_word(config_word), .core_evt(core_evt),
  .bus_req(bus_req), .rd_data(rd_data), .core_reset_b(core_reset_b), .core_run(core_run),
  .timer_watchdog_option(timer_watchdog_option), .irq(irq),
  .divided_clock_output(divided_clock_output));
